/* core/pwm_pkg.sv */
// Shared constants, types and decode functions for the 16-bit PWM timer
package pwm_pkg;

  // Counter width served by the logic
  localparam int          CNT_W      = 16;
  // Special counter values
  localparam logic [15:0] BOTTOM     = 16'h0000;
  localparam logic [15:0] MAX        = 16'hffff;
  localparam logic [15:0] TOP_8BIT   = 16'h00ff;
  localparam logic [15:0] TOP_9BIT   = 16'h01ff;
  localparam logic [15:0] TOP_10BIT  = 16'h03ff;
  localparam logic [15:0] MIN_TOP    = 16'h0003;
  // Values after reset
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  localparam logic [15:0] CMP_RESET  = 16'h0000;
  localparam logic [15:0] CAP_RESET  = 16'h0000;
  localparam logic        WAVE_RESET = 1'b0;

  // Waveform mode codes
  localparam logic [3:0] MODE_NORMAL  = 4'h0;
  localparam logic [3:0] MODE_PC8     = 4'h1;
  localparam logic [3:0] MODE_PC9     = 4'h2;
  localparam logic [3:0] MODE_PC10    = 4'h3;
  localparam logic [3:0] MODE_FP8     = 4'h5;
  localparam logic [3:0] MODE_FP9     = 4'h6;
  localparam logic [3:0] MODE_FP10    = 4'h7;
  localparam logic [3:0] MODE_PC_CAP  = 4'ha;
  localparam logic [3:0] MODE_PC_CMPA = 4'hb;
  localparam logic [3:0] MODE_FP_CAP  = 4'he;
  localparam logic [3:0] MODE_FP_CMPA = 4'hf;

  // Output action codes
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_NONINV = 2'h2;
  localparam logic [1:0] ACT_INV    = 2'h3;

  // Counting direction, one-hot
  typedef enum logic [1:0] {
    DIR_UP   = 2'b01,
    DIR_DOWN = 2'b10
  } dir_t;

  // Family of the selected waveform mode, one-hot
  typedef enum logic [2:0] {
    KIND_OTHER = 3'b001,
    KIND_PHASE = 3'b010,
    KIND_FAST  = 3'b100
  } kind_t;

  // Sticky event flags
  typedef struct packed {
    logic       ovf;   // Overflow flag
    logic       cap;   // Capture flag
    logic [1:0] cmp;   // Compare flags, bit 0 is channel A
  } flags_t;

  // Compare register write request
  typedef struct packed {
    logic [1:0]  wr;   // One strobe per channel
    logic [15:0] data; // Value written
  } cmp_write_t;

  // Family of a mode code
  function automatic kind_t kind_of(input logic [3:0] mode);
    unique case (mode)
      MODE_PC8, MODE_PC9, MODE_PC10, MODE_PC_CAP, MODE_PC_CMPA: kind_of = KIND_PHASE;
      MODE_FP8, MODE_FP9, MODE_FP10, MODE_FP_CAP, MODE_FP_CMPA: kind_of = KIND_FAST;
      default:                                                  kind_of = KIND_OTHER;
    endcase
  endfunction : kind_of

  // Mask applied to compare writes; all ones unless a fixed TOP is chosen
  function automatic logic [15:0] mask_of(input logic [3:0] mode);
    unique case (mode)
      MODE_PC8,  MODE_FP8:  mask_of = TOP_8BIT;
      MODE_PC9,  MODE_FP9:  mask_of = TOP_9BIT;
      MODE_PC10, MODE_FP10: mask_of = TOP_10BIT;
      default:              mask_of = MAX;
    endcase
  endfunction : mask_of

  // TOP for a mode, from the fixed values, capture register or compare A
  function automatic logic [15:0] top_of(input logic [3:0]  mode,
                                         input logic [15:0] cap,
                                         input logic [15:0] cmpa);
    unique case (mode)
      MODE_PC_CAP,  MODE_FP_CAP:  top_of = cap;
      MODE_PC_CMPA, MODE_FP_CMPA: top_of = cmpa;
      MODE_NORMAL:                top_of = MAX;
      default:                    top_of = mask_of(mode);
    endcase
  endfunction : top_of

  // True where compare A sets TOP
  function automatic logic top_is_cmpa(input logic [3:0] mode);
    top_is_cmpa = (mode == MODE_PC_CMPA) || (mode == MODE_FP_CMPA);
  endfunction : top_is_cmpa

  // True where the capture register sets TOP
  function automatic logic top_is_cap(input logic [3:0] mode);
    top_is_cap = (mode == MODE_PC_CAP) || (mode == MODE_FP_CAP);
  endfunction : top_is_cap

endpackage : pwm_pkg

/* core/compare_channel.sv */
// One compare unit: buffered compare value, match and output waveform
`timescale 1ns/1ns
module compare_channel #(
  parameter bit TOGGLE_OK = 1'b0           // Channel may use the toggle action
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  // Enables
  input  wire logic                clk_en_i,    // Freezes all state when low
  input  wire logic                tick_i,      // Timer step, already gated
  // Configuration
  input  wire logic [3:0]          mode_i,
  input  wire pwm_pkg::kind_t      kind_i,
  input  wire logic [1:0]          action_i,
  // Software write
  input  wire logic                wr_i,
  input  wire logic [15:0]         wr_data_i,
  // Counter state
  input  wire logic [15:0]         cnt_i,
  input  wire logic [15:0]         top_i,
  input  wire logic                at_top_i,
  input  wire pwm_pkg::dir_t       dir_i,
  // Results
  output logic      [15:0]         value_o,     // Active compare value
  output logic                     match_o,     // Counter equals active value
  output logic                     wave_o       // Internal waveform
);

  logic [15:0] buffer;       // Software side of the double buffer
  logic [15:0] next_buffer;
  logic [15:0] next_value;
  logic        next_wave;
  logic [15:0] masked;       // Write data after resolution masking
  logic        inv;          // Inverted polarity

  // Equality only: a value above TOP matches only when the counter runs past a lowered TOP
  assign match_o = (cnt_i == value_o); // [RULE13]
  assign inv     = action_i[0];
  assign masked  = wr_data_i & pwm_pkg::mask_of(mode_i); // [RULE12]

  // Next buffer, active value and waveform
  always_comb begin
    next_buffer = buffer;
    next_value  = value_o;
    next_wave   = wave_o;
    // Writes land in the buffer in PWM modes, directly elsewhere
    if (clk_en_i && wr_i) begin
      next_buffer = masked; // [RULE23]
      if (kind_i == pwm_pkg::KIND_OTHER) begin
        next_value = masked;
      end
    end
    // Buffer loads into the active value only at TOP
    if (tick_i && at_top_i && kind_i != pwm_pkg::KIND_OTHER) begin
      next_value = buffer; // [RULE23] [RULE4] [RULE14] [RULE22]
    end
    // Waveform actions on timer steps
    if (tick_i && kind_i != pwm_pkg::KIND_OTHER) begin
      if (action_i == pwm_pkg::ACT_TOGGLE) begin
        // Toggle only for channel A with compare A as TOP
        if (TOGGLE_OK && pwm_pkg::top_is_cmpa(mode_i) && match_o) begin
          next_wave = ~wave_o; // [RULE3] [RULE19]
        end
      end else if (action_i[1]) begin
        if (kind_i == pwm_pkg::KIND_FAST) begin
          // Set at TOP to BOTTOM wins over a match at TOP
          if (at_top_i) begin
            next_wave = ~inv; // [RULE1] [RULE2]
          end else if (match_o) begin
            next_wave = inv; // [RULE1]
          end
        end else if (match_o) begin
          // Dual slope: extremes give steady levels
          if (value_o == top_i) begin
            next_wave = ~inv; // [RULE18]
          end else if (value_o == pwm_pkg::BOTTOM) begin
            next_wave = inv; // [RULE18]
          end else if (dir_i == pwm_pkg::DIR_UP) begin
            next_wave = inv; // [RULE6] [RULE16]
          end else begin
            next_wave = ~inv; // [RULE6] [RULE16]
          end
        end
      end
    end
  end

  // Register stage
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      buffer  <= pwm_pkg::CMP_RESET;
      value_o <= pwm_pkg::CMP_RESET;
      wave_o  <= pwm_pkg::WAVE_RESET;
    end else if (clk_en_i) begin
      buffer  <= next_buffer;
      value_o <= next_value;
      wave_o  <= next_wave;
    end
  end

endmodule : compare_channel

/* core/timer16_pwm_waveform_modes.sv */
// 16-bit timer waveform generation: fast PWM extremes and phase correct PWM
// Operation
// [RULE1] Fast PWM, compare at BOTTOM gives spike
// [RULE2] Fast PWM, compare at TOP gives steady level
// [RULE3] Fast PWM toggle on A gives 50% duty
// [RULE4] Compare A stays double-buffered while toggling
// [RULE5] Phase correct counts up then down
// [RULE6] Clear on up match, set on down match
// [RULE7] TOP from fixed values, capture or compare A
// [RULE8] Counter holds TOP one step, then descends
// [RULE9] Overflow flag set at every BOTTOM
// [RULE10] Compare A or capture flag set at TOP
// [RULE11] Resolution from 2 to 16 bits
// [RULE12] Fixed TOP masks high compare bits on write
// [RULE13] Software keeps TOP at or above compares
// [RULE14] Periods start and end at TOP
// [RULE15] Software prefers other mode when changing TOP
// [RULE16] Action 0x2 non-inverted, 0x3 inverted
// [RULE17] Pin driven only when direction is output
// [RULE18] BOTTOM gives steady low, TOP steady high
// [RULE19] Mode 0xB toggle on A gives 50%
// [RULE20] Frequency follows prescale step rate and TOP
// [RULE21] Capture register unbuffered, takes writes at once
// [RULE22] Everything advances only on timer steps
// [RULE23] Compare writes land in buffer first
`timescale 1ns/1ns
module timer16_pwm_waveform_modes #(
  parameter int CNT_W = pwm_pkg::CNT_W    // Counter width, only 16 served
) (
  // Clock and reset
  input  wire logic                clk_sys_i,
  input  wire logic                resetn_i,
  // Enables
  input  wire logic                clk_en_i,             // Freezes all state
  input  wire logic                timer_tick_i,         // Prescaled timer step
  // Configuration
  input  wire logic [3:0]          waveform_mode_sel_i,
  input  wire logic [1:0]          output_action_a_sel_i,
  input  wire logic [1:0]          output_action_b_sel_i,
  // Register writes
  input  wire pwm_pkg::cmp_write_t compare_write_i,
  input  wire logic                capture_wr_i,
  input  wire logic [15:0]         capture_wr_data_i,
  // Flag clears, one strobe per flag
  input  wire pwm_pkg::flags_t     flag_clear_i,
  // Pin direction, high for output
  input  wire logic [1:0]          wave_pin_direction_i,
  // Status
  output logic      [15:0]         counter_value_o,
  output logic                     count_down_o,
  output logic      [15:0]         compare_a_value_o,
  output logic      [15:0]         compare_b_value_o,
  output logic      [15:0]         capture_top_value_o,
  output pwm_pkg::flags_t          flags_o,
  // Waveforms
  output logic      [1:0]          wave_output_o,        // Internal waveform
  output logic      [1:0]          wave_pin_o,           // Pin output value
  output logic      [1:0]          wave_pin_oe_n_o       // Low while driving
);

  // Refuse widths the logic does not serve
  if (CNT_W != pwm_pkg::CNT_W) begin : g_width_check
    $error("timer16_pwm_waveform_modes: CNT_W must be 16");
  end

  logic              tick;          // Timer step gated by the clock enable
  pwm_pkg::kind_t    kind;          // Family of the selected mode
  logic [15:0]       top;           // Current TOP
  logic              at_top;        // Counter equals TOP
  logic              at_bottom;     // Counter equals BOTTOM
  pwm_pkg::dir_t     dir;           // Counting direction
  pwm_pkg::dir_t     next_dir;
  logic [15:0]       next_cnt;
  logic [15:0]       next_cap;
  pwm_pkg::flags_t   set_flags;     // Events in this step
  pwm_pkg::flags_t   next_flags;
  logic [1:0]        match;         // Per-channel compare match
  logic [15:0]       cmp_value [2]; // Active compare values
  logic [1:0]        action [2];    // Per-channel output action

  assign tick         = clk_en_i & timer_tick_i; // [RULE22]
  assign kind         = pwm_pkg::kind_of(waveform_mode_sel_i); // [RULE5]
  // TOP from fixed value, capture register or active compare A
  assign top          = pwm_pkg::top_of(waveform_mode_sel_i, capture_top_value_o,
                                        cmp_value[0]); // [RULE7] [RULE11]
  assign at_top       = (counter_value_o == top); // [RULE13] [RULE21]
  assign at_bottom    = (counter_value_o == pwm_pkg::BOTTOM);
  assign count_down_o = (dir == pwm_pkg::DIR_DOWN);
  assign action[0]    = output_action_a_sel_i;
  assign action[1]    = output_action_b_sel_i;
  assign compare_a_value_o = cmp_value[0];
  assign compare_b_value_o = cmp_value[1];

  // Two compare units; only channel A may toggle
  for (genvar i = 0; i < 2; i++) begin : g_chan
    compare_channel #(
      .TOGGLE_OK (i == 0)
    ) u_chan (
      .clk_sys_i (clk_sys_i),
      .resetn_i  (resetn_i),
      .clk_en_i  (clk_en_i),
      .tick_i    (tick),
      .mode_i    (waveform_mode_sel_i),
      .kind_i    (kind),
      .action_i  (action[i]),
      .wr_i      (compare_write_i.wr[i]),
      .wr_data_i (compare_write_i.data),
      .cnt_i     (counter_value_o),
      .top_i     (top),
      .at_top_i  (at_top),
      .dir_i     (dir),
      .value_o   (cmp_value[i]),
      .match_o   (match[i]),
      .wave_o    (wave_output_o[i])
    );
  end

  // Pin gating by direction
  always_comb begin
    wave_pin_o      = wave_output_o & wave_pin_direction_i; // [RULE17]
    wave_pin_oe_n_o = ~wave_pin_direction_i; // [RULE17]
  end

  // Next counter value and direction
  always_comb begin
    next_cnt = counter_value_o;
    next_dir = dir;
    if (tick) begin
      // One step per timer tick sets the output frequency
      unique case (kind)
        pwm_pkg::KIND_PHASE: begin
          unique case (dir)
            pwm_pkg::DIR_UP: begin
              if (at_top) begin
                // TOP was shown for this step; descend next
                next_cnt = counter_value_o - 16'h0001; // [RULE8] [RULE20]
                next_dir = pwm_pkg::DIR_DOWN; // [RULE5] [RULE8]
              end else begin
                // Passing a lowered TOP runs on to MAX and wraps
                next_cnt = counter_value_o + 16'h0001; // [RULE21]
              end
            end
            pwm_pkg::DIR_DOWN: begin
              if (at_bottom) begin
                next_cnt = counter_value_o + 16'h0001; // [RULE5]
                next_dir = pwm_pkg::DIR_UP;
              end else begin
                next_cnt = counter_value_o - 16'h0001; // [RULE14]
              end
            end
            default: begin
              // Illegal direction code recovers to counting up
              next_dir = pwm_pkg::DIR_UP;
            end
          endcase
        end
        pwm_pkg::KIND_FAST: begin
          // Single slope: TOP is followed by BOTTOM
          next_cnt = at_top ? pwm_pkg::BOTTOM : counter_value_o + 16'h0001;
          next_dir = pwm_pkg::DIR_UP;
        end
        pwm_pkg::KIND_OTHER: begin
          // Plain up count with wrap
          next_cnt = counter_value_o + 16'h0001;
          next_dir = pwm_pkg::DIR_UP;
        end
        default: begin
          next_dir = pwm_pkg::DIR_UP;
        end
      endcase
    end
  end

  // Capture register: no buffer, writes take effect at once
  always_comb begin
    next_cap = capture_top_value_o;
    if (clk_en_i && capture_wr_i) begin
      next_cap = capture_wr_data_i; // [RULE21]
    end
  end

  // Flag events and sticky flags; a set wins over a clear
  always_comb begin
    set_flags = '0;
    if (tick) begin
      unique case (kind)
        pwm_pkg::KIND_PHASE: set_flags.ovf = at_bottom; // [RULE9]
        pwm_pkg::KIND_FAST:  set_flags.ovf = at_top;
        default:             set_flags.ovf = (counter_value_o == pwm_pkg::MAX);
      endcase
      set_flags.cmp = match;
      // TOP flags come with the buffer load at TOP
      if (kind != pwm_pkg::KIND_OTHER && at_top) begin
        set_flags.cap = pwm_pkg::top_is_cap(waveform_mode_sel_i); // [RULE10]
        if (pwm_pkg::top_is_cmpa(waveform_mode_sel_i)) begin
          set_flags.cmp[0] = 1'b1; // [RULE10]
        end
      end
    end
    next_flags = (flags_o & ~flag_clear_i) | set_flags;
  end

  // Register stage for counter, direction, capture and flags
  always_ff @(posedge clk_sys_i) begin
    if (!resetn_i) begin
      counter_value_o     <= pwm_pkg::CNT_RESET;
      dir                 <= pwm_pkg::DIR_UP;
      capture_top_value_o <= pwm_pkg::CAP_RESET;
      flags_o             <= '0;
    end else if (clk_en_i) begin
      counter_value_o     <= next_cnt;
      dir                 <= next_dir;
      capture_top_value_o <= next_cap;
      flags_o             <= next_flags;
    end
  end

endmodule : timer16_pwm_waveform_modes

/* verif/timer16_pwm_props.sv */
// Port-level checker for the 16-bit PWM waveform timer
`timescale 1ns/1ns
module timer16_pwm_props (
  // Clock, reset and enables
  input wire logic            clk_sys_i,
  input wire logic            resetn_i,
  input wire logic            clk_en_i,
  input wire logic            timer_tick_i,
  // Configuration
  input wire logic [3:0]      waveform_mode_sel_i,
  input wire logic [1:0]      output_action_a_sel_i,
  input wire logic [1:0]      wave_pin_direction_i,
  // Observed state
  input wire logic [15:0]     counter_value_o,
  input wire logic            count_down_o,
  input wire logic [15:0]     capture_top_value_o,
  input wire logic [15:0]     compare_a_value_o,
  input wire pwm_pkg::flags_t flags_o,
  input wire logic [1:0]      wave_output_o,
  input wire logic [1:0]      wave_pin_o,
  input wire logic [1:0]      wave_pin_oe_n_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  // Enabled timer step
  wire logic step_en = clk_en_i && timer_tick_i;
  // Dual-slope mode selected
  wire logic phase = waveform_mode_sel_i inside {4'h1, 4'h2, 4'h3, 4'ha, 4'hb};
  // Mode 0xA, capture register sets TOP and the counter is at it
  wire logic cap_top = (waveform_mode_sel_i == 4'ha) && (counter_value_o == capture_top_value_o);

  ovf_at_bottom_a: assert property (step_en && phase && counter_value_o == 16'h0000 |=> flags_o.ovf)
    else $error("overflow flag missing after bottom");
  cap_at_top_a: assert property (step_en && cap_top |=> flags_o.cap)
    else $error("capture flag missing after top");
  top_once_a: assert property (step_en && cap_top && counter_value_o != 16'h0000
    |=> counter_value_o == $past(counter_value_o) - 16'h0001)
    else $error("counter did not turn down after top");
  up_slope_a: assert property (step_en && waveform_mode_sel_i == 4'ha && !count_down_o
    && counter_value_o < capture_top_value_o |=> counter_value_o == $past(counter_value_o) + 16'h0001)
    else $error("counter did not rise on up slope");
  fast_wrap_a: assert property (step_en && waveform_mode_sel_i == 4'he
    && counter_value_o == capture_top_value_o |=> counter_value_o == 16'h0000)
    else $error("fast counter did not wrap at top");
  pin_gate_a: assert property (wave_pin_o == (wave_output_o & wave_pin_direction_i)
    && wave_pin_oe_n_o == ~wave_pin_direction_i)
    else $error("pin drive not gated by direction");
  frozen_state_a: assert property (!clk_en_i |=> $stable(counter_value_o) && $stable(flags_o)
    && $stable(wave_output_o))
    else $error("state moved while clock enable low");
  no_step_a: assert property (clk_en_i && !timer_tick_i |=> $stable(counter_value_o))
    else $error("counter moved without a timer step");
  toggle_a: assert property (step_en && waveform_mode_sel_i inside {4'hb, 4'hf}
    && output_action_a_sel_i == 2'h1 && counter_value_o == compare_a_value_o
    |=> $changed(wave_output_o[0]))
    else $error("channel a did not toggle on match");
endmodule : timer16_pwm_props

bind timer16_pwm_waveform_modes timer16_pwm_props i_timer16_pwm_props (.clk_sys_i, .resetn_i,
  .clk_en_i, .timer_tick_i, .waveform_mode_sel_i, .output_action_a_sel_i, .wave_pin_direction_i,
  .counter_value_o, .count_down_o, .capture_top_value_o, .compare_a_value_o, .flags_o,
  .wave_output_o, .wave_pin_o,
  .wave_pin_oe_n_o);

/* verif/wave_pin_sink.sv */
// Port pin model: pulled down when released, counts cycles spent high
`timescale 1ns/1ns
module wave_pin_sink (
  // Clock
  input  wire logic        clk_sys_i,
  // Pin drive from the timer
  input  wire logic        pin_i,
  input  wire logic        oe_n_i,
  // Measurement window
  input  wire logic        clr_i,
  output logic      [15:0] high_cnt_o
);
  // Released pin falls to the pull-down level
  wire logic level = oe_n_i ? 1'b0 : pin_i;
  // Count high cycles until cleared
  always @(posedge clk_sys_i) begin
    if (clr_i) begin
      high_cnt_o <= 16'h0000;
    end else if (level === 1'b1) begin
      high_cnt_o <= high_cnt_o + 16'h0001;
    end
  end
endmodule : wave_pin_sink

/* verif/test_timer16_pwm_waveform_modes.sv */
// Self-checking bench for the 16-bit PWM waveform timer
`timescale 1ns/1ns
`define CHK(n, e, a) begin samples_checked++; if ((a) !== (e)) begin num_errors++; \
  $display("Error %s expected %h seen %h", n, e, a); end end
module test_timer16_pwm_waveform_modes;
  logic                clk_sys_i, resetn_i, clk_en_i, timer_tick_i, capture_wr_i, pin_clr;
  logic [3:0]          waveform_mode_sel_i;
  logic [1:0]          output_action_a_sel_i, output_action_b_sel_i, wave_pin_direction_i;
  logic [1:0]          wave_output_o, wave_pin_o, wave_pin_oe_n_o, act;
  logic [15:0]         capture_wr_data_i, counter_value_o, compare_a_value_o, compare_b_value_o;
  logic [15:0]         capture_top_value_o, rcnt, rtop, hi_a, hi_b, cb, eb;
  logic                count_down_o, rdown, rfast;
  pwm_pkg::cmp_write_t compare_write_i;
  pwm_pkg::flags_t     flag_clear_i, flags_o;
  int                  num_errors, samples_checked, cyc;

  timer16_pwm_waveform_modes i_timer16_pwm_waveform_modes (.clk_sys_i, .resetn_i, .clk_en_i,
    .timer_tick_i, .waveform_mode_sel_i, .output_action_a_sel_i, .output_action_b_sel_i,
    .compare_write_i, .capture_wr_i, .capture_wr_data_i, .flag_clear_i, .wave_pin_direction_i,
    .counter_value_o, .count_down_o, .compare_a_value_o, .compare_b_value_o,
    .capture_top_value_o, .flags_o, .wave_output_o, .wave_pin_o, .wave_pin_oe_n_o);
  // Pin models on both channels
  wave_pin_sink i_sink_a (.clk_sys_i, .pin_i(wave_pin_o[0]), .oe_n_i(wave_pin_oe_n_o[0]),
    .clr_i(pin_clr), .high_cnt_o(hi_a));
  wave_pin_sink i_sink_b (.clk_sys_i, .pin_i(wave_pin_o[1]), .oe_n_i(wave_pin_oe_n_o[1]),
    .clr_i(pin_clr), .high_cnt_o(hi_b));

  // Clock, 10 ns period
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end

  // Reference counter on enabled steps, plus run-time ceiling
  always @(posedge clk_sys_i) begin
    cyc <= cyc + 1;
    if (!resetn_i) begin
      rcnt  <= 16'h0000;
      rdown <= 1'b0;
    end else if (clk_en_i && timer_tick_i) begin
      if (rfast) rcnt <= (rcnt == rtop) ? 16'h0000 : rcnt + 16'h0001;
      else if (!rdown && rcnt == rtop) begin
        rdown <= 1'b1;
        rcnt  <= rcnt - 16'h0001;
      end else if (rdown && rcnt == 16'h0000) begin
        rdown <= 1'b0;
        rcnt  <= 16'h0001;
      end else rcnt <= rdown ? rcnt - 16'h0001 : rcnt + 16'h0001;
    end
    if (cyc == 6000) begin
      num_errors++;
      close_out();
    end
  end

  // Counter compared every cycle
  always @(negedge clk_sys_i) begin
    if (resetn_i) `CHK("counter", rcnt, counter_value_o)
    if (resetn_i) `CHK("direction", rdown, count_down_o)
  end

  task automatic step(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask : step

  // Compare register write, one cycle strobe
  task automatic wr(input logic [1:0] w, input logic [15:0] d);
    compare_write_i = {w, d};
    step(1);
    compare_write_i = '0;
  endtask : wr

  // Reset, load registers in plain mode with steps off, then start
  task automatic setup(input logic [3:0] m, input logic [1:0] aa, ab,
                       input logic [15:0] a, b, c, t, input logic f);
    timer_tick_i        = 1'b0;
    waveform_mode_sel_i = 4'h0;
    resetn_i            = 1'b0;
    step(2);
    resetn_i = 1'b1;
    wr(2'b01, a);
    wr(2'b10, b);
    capture_wr_i      = 1'b1;
    capture_wr_data_i = c;
    step(1);
    capture_wr_i = 1'b0;
    `CHK("capture", c, capture_top_value_o)
    waveform_mode_sel_i   = m;
    output_action_a_sel_i = aa;
    output_action_b_sel_i = ab;
    rtop                  = t;
    rfast                 = f;
    timer_tick_i          = 1'b1;
  endtask : setup

  // High cycles seen on both pins over a window
  task automatic duty(input logic [15:0] ea, input logic [15:0] ebv, input int n);
    pin_clr = 1'b1;
    step(1);
    pin_clr = 1'b0;
    step(n);
    `CHK("high cycles a", ea, hi_a)
    `CHK("high cycles b", ebv, hi_b)
  endtask : duty

  task automatic close_out();
    $display("checks %0d errors %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  // Main sequence
  initial begin
    num_errors = 0; samples_checked = 0; cyc = 0; pin_clr = 1'b0; rfast = 1'b0; rtop = 16'h0000;
    resetn_i = 1'b0; clk_en_i = 1'b1; timer_tick_i = 1'b0; waveform_mode_sel_i = 4'h0;
    output_action_a_sel_i = 2'h0; output_action_b_sel_i = 2'h0; compare_write_i = '0;
    capture_wr_i = 1'b0; capture_wr_data_i = 16'h0000; flag_clear_i = '0;
    wave_pin_direction_i = 2'b11;
    repeat (8) @(negedge clk_sys_i);
    resetn_i = 1'b1;
    // Phase correct with TOP from capture: polarity and extreme compares
    for (int i = 0; i < 4; i++) begin
      act = i[0] ? pwm_pkg::ACT_INV : pwm_pkg::ACT_NONINV;
      cb  = i[1] ? 16'h0000 : 16'h0002;
      eb  = i[0] ? 16'h0014 - (cb << 2) : cb << 2;
      setup(pwm_pkg::MODE_PC_CAP, act, act, 16'h0005, cb, 16'h0005, 16'h0005, 1'b0);
      step(20);
      duty(i[0] ? 16'h0000 : 16'h0014, eb, 20);
    end
    // Buffered compare update waits for TOP
    wr(2'b10, 16'h0003);
    `CHK("compare b held", 16'h0000, compare_b_value_o)
    step(12);
    `CHK("compare b loaded", 16'h0003, compare_b_value_o)
    // Flag clear away from BOTTOM and TOP
    repeat (12) if (counter_value_o !== 16'h0003) step(1);
    flag_clear_i = 4'b1100;
    step(1);
    flag_clear_i = '0;
    `CHK("overflow cleared", 1'b0, flags_o.ovf)
    `CHK("capture cleared", 1'b0, flags_o.cap)
    // Pins released when direction is input
    wave_pin_direction_i = 2'b00;
    duty(16'h0000, 16'h0000, 20);
    `CHK("pin enables", 2'b11, wave_pin_oe_n_o)
    wave_pin_direction_i = 2'b11;
    // Dual-slope toggle, TOP from compare A at minimum resolution
    setup(pwm_pkg::MODE_PC_CMPA, pwm_pkg::ACT_TOGGLE, pwm_pkg::ACT_OFF, 16'h0003, 16'h0000,
          16'h0000, 16'h0003, 1'b0);
    step(12);
    duty(16'h000c, 16'h0000, 24);
    `CHK("compare a flag", 1'b1, flags_o.cmp[0])
    // Single-slope toggle at compare A zero, B steady at TOP
    setup(pwm_pkg::MODE_FP_CMPA, pwm_pkg::ACT_TOGGLE, pwm_pkg::ACT_NONINV, 16'h0000, 16'h0000,
          16'h0000, 16'h0000, 1'b1);
    step(4);
    duty(16'h000c, 16'h0018, 24);
    // Single-slope extremes, both polarities
    for (int i = 0; i < 2; i++) begin
      act = i[0] ? pwm_pkg::ACT_INV : pwm_pkg::ACT_NONINV;
      setup(pwm_pkg::MODE_FP_CAP, act, act, 16'h0007, 16'h0000, 16'h0007, 16'h0007, 1'b1);
      step(16);
      duty(i[0] ? 16'h0000 : 16'h0020, i[0] ? 16'h001c : 16'h0004, 32);
    end
    // Fixed 8-bit TOP, prescaled steps with enable gaps, masked write
    setup(pwm_pkg::MODE_PC8, pwm_pkg::ACT_NONINV, pwm_pkg::ACT_NONINV, 16'h0010, 16'h0020,
          16'h0000, 16'h00ff, 1'b0);
    wr(2'b11, 16'habcd);
    for (int k = 1; k <= 1400; k++) begin
      timer_tick_i = ~timer_tick_i;
      clk_en_i     = (k % 7) != 0;
      step(1);
    end
    clk_en_i = 1'b1;
    `CHK("masked compare a", 16'h00cd, compare_a_value_o)
    `CHK("masked compare b", 16'h00cd, compare_b_value_o)
    close_out();
  end
endmodule : test_timer16_pwm_waveform_modes
